// ==== logic/cache_tag_defs.vh ====
// cache_tag_defs.vh: constants for the write-back cache tag controller
// assumes inclusion by bare name from the logic/ sources
`ifndef CACHE_TAG_DEFS_VH
`define CACHE_TAG_DEFS_VH

// ----------------------------------------
// controller states
// ----------------------------------------
`define ST_CLEAR 4'h0
`define ST_IDLE 4'h1
`define ST_LOOK 4'h2
`define ST_DECIDE 4'h3
`define ST_RDHIT 4'h4
`define ST_WRHIT 4'h5
`define ST_WBACK 4'h6
`define ST_FILL 4'h7
`define ST_BYPASS 4'h8
`define ST_DONE 4'h9

// ----------------------------------------
// cache size codes
// ----------------------------------------
`define SIZE_64K 2'h0
`define SIZE_512K 2'h3

// ----------------------------------------
// burst timing
// ----------------------------------------
`define LEAD_WAIT_FAST 2'h1
`define LEAD_WAIT_SLOW 2'h2
`define BEAT_WAIT_FAST 2'h0
`define BEAT_WAIT_SLOW 2'h1

// ----------------------------------------
// line and index geometry
// ----------------------------------------
`define LAST_BEAT 2'h3
`define IDX_LOW_MASK 12'hfff
`define TAG_SHIFT_BASE 5'hc
`define DIRTY_ENTRIES 32768
`define NC_REGIONS 3

`endif

// ==== logic/dirty_bit_store.v ====
// dirty_bit_store.v: one modified flag per tag entry, registered read
// assumes single clock, write and read addressed by the same index
`timescale 1ns/1ns
`default_nettype none
`include "cache_tag_defs.vh"

module dirty_bit_store (
    // clock
    input wire clk,
    // access
    input wire [14:0] addr,
    input wire wr_en,
    input wire wr_data,
    output wire rd_data
);

    reg mem [0:`DIRTY_ENTRIES-1];
    reg rd_data_reg;

    // ----------------------------------------
    // storage
    // ----------------------------------------
    always @(posedge clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
        rd_data_reg <= mem[addr];
    end

    assign rd_data = rd_data_reg;

endmodule // dirty_bit_store

`default_nettype wire

// ==== logic/uncached_region_check.v ====
// uncached_region_check.v: three programmable non-cacheable windows
// assumes bases aligned to the window size, same clock as the controller
`timescale 1ns/1ns
`default_nettype none
`include "cache_tag_defs.vh"

module uncached_region_check (
    // clock and reset
    input wire clk,
    input wire rstn,
    // address a31..a16
    input wire [15:0] addr_hi,
    // window settings
    input wire [2:0] win_enable,
    input wire [47:0] win_base,
    input wire [5:0] win_size,
    // result
    output wire uncached
);

    wire [2:0] win_hit;
    reg uncached_reg;

    // ----------------------------------------
    // per-window compare
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < `NC_REGIONS; g = g + 1) begin : win
            wire [15:0] mask;
            assign mask = 16'hffff << win_size[2*g+1:2*g];
            assign win_hit[g] = win_enable[g] &&
                ((addr_hi & mask) == (win_base[16*g+15:16*g] & mask));
        end
    endgenerate

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            uncached_reg <= 1'b0;
        end else begin
            uncached_reg <= |win_hit;
        end
    end

    assign uncached = uncached_reg;

endmodule // uncached_region_check

`default_nettype wire

// ==== logic/writeback_cache_tag_control.v ====
// writeback_cache_tag_control.v: secondary write-back cache tag controller
// assumes external tag/data srams, a dram port answering with mem_ack
//
// What this block does
// - Open strap reads high, selecting earlier-processor mode.
// - Bank phase derives from the double-rate clock.
// - State machine runs on the master clock.
// - Board reset resets the block.
// - Cache sizes 64k to 512k selectable.
// - No pipelining; sixteen-byte lines of four beats.
// - Hit compares high address bits with stored tag.
// - Hit only on tag match at a cacheable address.
// - Mismatch, uncached window or shadow gives a miss.
// - One modified flag per tag entry.
// - Dirty victim written back before replacement.
// - Whole line written back, then line fill.
// - Later mode: works beside the cpu internal cache.
// - Later mode: data srams may interleave.
// - Burst timings 2-1-1-1 to 3-2-2-2.
// - Zero or one wait state on cpu write hits.
// - Three programmable non-cacheable regions.
// - Cpu write hit updates cache, sets modified flag.
// - After write-back, line filled, flag cleared.
// - Master write hit writes both, strobes snoop invalidate.
// - Write miss goes to memory, flag untouched.
`timescale 1ns/1ns
`default_nettype none
`include "cache_tag_defs.vh"

module writeback_cache_tag_control #(
    parameter CLEAR_ENTRIES = `DIRTY_ENTRIES
) (
    // clocks and reset
    input wire clk,
    input wire rstn,
    input wire double_rate_clock,
    // strap and configuration
    input wire cpu_type_strap,
    input wire [1:0] cache_size_sel,
    input wire [1:0] burst_sel,
    input wire write_hit_wait,
    input wire shadow_uncached,
    // non-cacheable windows
    input wire [2:0] uncached_enable,
    input wire [15:0] uncached_window_zero,
    input wire [15:0] uncached_window_one,
    input wire [15:0] uncached_window_two,
    input wire [5:0] uncached_size,
    // cycle request
    input wire cyc_req,
    input wire cyc_write,
    input wire cyc_master,
    input wire [31:2] cyc_addr,
    output wire cyc_done,
    output wire cpu_ready,
    // tag sram
    output wire [14:0] tag_index,
    input wire [8:0] tag_rdata,
    output wire [8:0] tag_wdata,
    output wire tag_we_n,
    // data sram
    output wire [16:0] cache_addr,
    output wire cache_oe_n,
    output wire cache_we_n,
    output wire cache_interleave,
    output wire cache_bank_sel,
    // dram
    output wire mem_req,
    output wire mem_write,
    output wire [31:2] mem_addr,
    input wire mem_ack,
    // processor coherency
    output wire snoop_invalidate_strobe_n,
    // status
    output wire later_mode,
    output wire ready_idle,
    output wire last_hit
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg strap_s1_reg, strap_s2_reg, strap_taken_reg, later_mode_reg;
    reg dr_s1_reg, dr_s2_reg, phase_reg;
    reg [3:0] state_reg;
    reg [31:2] addr_reg;
    reg wr_reg, master_reg, hit_reg, dirty_reg;
    reg [8:0] victim_reg;
    reg [1:0] beat_reg, done_beats_reg, wait_reg;
    reg [14:0] clear_reg;
    reg cyc_done_reg, cpu_ready_reg;
    reg [14:0] tag_index_reg;
    reg [8:0] tag_wdata_reg;
    reg tag_we_n_reg;
    reg [16:0] cache_addr_reg;
    reg cache_oe_n_reg, cache_we_n_reg;
    reg mem_req_reg, mem_write_reg;
    reg [31:2] mem_addr_reg;
    reg snoop_n_reg;
    reg dmem_wr_reg, dmem_wdata_reg;

    // ----------------------------------------
    // address helpers
    // ----------------------------------------
    function [15:0] tag_part;
        input [31:2] a;
        input [1:0] sz;
        begin
            tag_part = a[31:16] >> sz;
        end
    endfunction

    function [14:0] index_of;
        input [31:2] a;
        input [1:0] sz;
        begin
            index_of = a[18:4] & {sz == `SIZE_512K, sz[1], sz != `SIZE_64K,
                `IDX_LOW_MASK};
        end
    endfunction

    function [27:0] victim_line;
        input [8:0] tag;
        input [1:0] sz;
        input [14:0] idx;
        begin
            victim_line = ({19'h0, tag} << (`TAG_SHIFT_BASE + {3'h0, sz})) |
                {13'h0, idx};
        end
    endfunction

    // ----------------------------------------
    // pin synchronisers and mode capture
    // ----------------------------------------
    always @(posedge clk) begin
        strap_s1_reg <= cpu_type_strap;
        strap_s2_reg <= strap_s1_reg;
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strap_taken_reg <= 1'b0;
            later_mode_reg <= 1'b0;
            dr_s1_reg <= 1'b0;
            dr_s2_reg <= 1'b0;
        end else begin
            dr_s1_reg <= double_rate_clock;
            dr_s2_reg <= dr_s1_reg;
            if (!strap_taken_reg) begin
                strap_taken_reg <= 1'b1;
                later_mode_reg <= !strap_s2_reg;
            end
        end
    end

    // ----------------------------------------
    // decision terms
    // ----------------------------------------
    wire [15:0] cur_tag_full;
    wire [14:0] cur_index;
    wire [14:0] in_index;
    wire beyond;
    wire nc_hit;
    wire dirty_rd;
    wire hit_now;
    wire [14:0] dmem_addr;
    wire burst_mode;
    wire [1:0] lead_wait;
    wire [1:0] beat_wait;

    assign cur_tag_full = tag_part(addr_reg, cache_size_sel);
    assign cur_index = index_of(addr_reg, cache_size_sel);
    assign in_index = index_of(cyc_addr, cache_size_sel);
    assign beyond = |cur_tag_full[15:9];
    assign hit_now = (tag_rdata == cur_tag_full[8:0]) &&
        !beyond && !nc_hit && !shadow_uncached;
    assign dmem_addr = (state_reg == `ST_CLEAR) ? clear_reg :
        (state_reg == `ST_IDLE) ? in_index : cur_index;
    assign burst_mode = later_mode_reg && !master_reg;
    assign lead_wait = burst_sel[0] ? `LEAD_WAIT_SLOW : `LEAD_WAIT_FAST;
    assign beat_wait = burst_sel[1] ? `BEAT_WAIT_SLOW : `BEAT_WAIT_FAST;

    uncached_region_check u_nc (
        .clk(clk),
        .rstn(rstn),
        .addr_hi(addr_reg[31:16]),
        .win_enable(uncached_enable),
        .win_base({uncached_window_two, uncached_window_one, uncached_window_zero}),
        .win_size(uncached_size),
        .uncached(nc_hit)
    );

    dirty_bit_store u_dirty (
        .clk(clk),
        .addr(dmem_addr),
        .wr_en(dmem_wr_reg || state_reg == `ST_CLEAR),
        .wr_data(dmem_wdata_reg && state_reg != `ST_CLEAR),
        .rd_data(dirty_rd)
    );

    // ----------------------------------------
    // controller
    // ----------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= `ST_CLEAR;
            addr_reg <= 30'h0;
            wr_reg <= 1'b0;
            master_reg <= 1'b0;
            hit_reg <= 1'b0;
            dirty_reg <= 1'b0;
            victim_reg <= 9'h0;
            beat_reg <= 2'h0;
            done_beats_reg <= 2'h0;
            wait_reg <= 2'h0;
            clear_reg <= 15'h0;
            phase_reg <= 1'b0;
            cyc_done_reg <= 1'b0;
            cpu_ready_reg <= 1'b0;
            tag_index_reg <= 15'h0;
            tag_wdata_reg <= 9'h0;
            tag_we_n_reg <= 1'b1;
            cache_addr_reg <= 17'h0;
            cache_oe_n_reg <= 1'b1;
            cache_we_n_reg <= 1'b1;
            mem_req_reg <= 1'b0;
            mem_write_reg <= 1'b0;
            mem_addr_reg <= 30'h0;
            snoop_n_reg <= 1'b1;
            dmem_wr_reg <= 1'b0;
            dmem_wdata_reg <= 1'b0;
        end else begin
            cyc_done_reg <= 1'b0;
            cpu_ready_reg <= 1'b0;
            tag_we_n_reg <= 1'b1;
            cache_we_n_reg <= 1'b1;
            snoop_n_reg <= 1'b1;
            dmem_wr_reg <= 1'b0;
            phase_reg <= !phase_reg;
            case (state_reg)
                `ST_CLEAR: begin
                    clear_reg <= clear_reg + 15'h1;
                    if (clear_reg == CLEAR_ENTRIES[14:0] - 15'h1) begin
                        state_reg <= `ST_IDLE;
                    end
                end
                `ST_IDLE: begin
                    phase_reg <= dr_s2_reg;
                    if (cyc_req) begin
                        addr_reg <= cyc_addr;
                        wr_reg <= cyc_write;
                        master_reg <= cyc_master;
                        tag_index_reg <= in_index;
                        state_reg <= `ST_LOOK;
                    end
                end
                `ST_LOOK: begin
                    state_reg <= `ST_DECIDE;
                end
                `ST_DECIDE: begin
                    hit_reg <= hit_now;
                    dirty_reg <= dirty_rd;
                    victim_reg <= tag_rdata;
                    beat_reg <= addr_reg[3:2];
                    done_beats_reg <= 2'h0;
                    cache_addr_reg <= {cur_index, addr_reg[3:2]};
                    if (wr_reg) begin
                        if (hit_now && !master_reg) begin
                            wait_reg <= {1'b0, write_hit_wait};
                            state_reg <= `ST_WRHIT;
                        end else begin
                            state_reg <= `ST_BYPASS;
                        end
                    end else if (hit_now) begin
                        wait_reg <= lead_wait;
                        cache_oe_n_reg <= 1'b0;
                        state_reg <= `ST_RDHIT;
                    end else if (master_reg || beyond || nc_hit || shadow_uncached) begin
                        state_reg <= `ST_BYPASS;
                    end else begin
                        beat_reg <= 2'h0;
                        if (dirty_rd) begin
                            cache_oe_n_reg <= 1'b0;
                            cache_addr_reg <= {cur_index, 2'h0};
                            state_reg <= `ST_WBACK;
                        end else begin
                            state_reg <= `ST_FILL;
                        end
                    end
                end
                `ST_RDHIT: begin
                    if (wait_reg != 2'h0) begin
                        wait_reg <= wait_reg - 2'h1;
                    end else begin
                        cpu_ready_reg <= !master_reg;
                        wait_reg <= beat_wait;
                        beat_reg <= beat_reg + 2'h1;
                        done_beats_reg <= done_beats_reg + 2'h1;
                        cache_addr_reg <= {cur_index, beat_reg + 2'h1};
                        if (!burst_mode || done_beats_reg == `LAST_BEAT) begin
                            cache_oe_n_reg <= 1'b1;
                            state_reg <= `ST_DONE;
                        end
                    end
                end
                `ST_WRHIT: begin
                    if (wait_reg != 2'h0) begin
                        wait_reg <= wait_reg - 2'h1;
                    end else begin
                        cache_we_n_reg <= 1'b0;
                        dmem_wr_reg <= 1'b1;
                        dmem_wdata_reg <= 1'b1;
                        cpu_ready_reg <= 1'b1;
                        state_reg <= `ST_DONE;
                    end
                end
                `ST_WBACK: begin
                    mem_req_reg <= 1'b1;
                    mem_write_reg <= 1'b1;
                    mem_addr_reg <= {victim_line(victim_reg, cache_size_sel, cur_index),
                        beat_reg};
                    if (mem_req_reg && mem_ack) begin
                        mem_req_reg <= 1'b0;
                        beat_reg <= beat_reg + 2'h1;
                        cache_addr_reg <= {cur_index, beat_reg + 2'h1};
                        if (beat_reg == `LAST_BEAT) begin
                            cache_oe_n_reg <= 1'b1;
                            state_reg <= `ST_FILL;
                        end
                    end
                end
                `ST_FILL: begin
                    mem_req_reg <= 1'b1;
                    mem_write_reg <= 1'b0;
                    mem_addr_reg <= {addr_reg[31:4], beat_reg};
                    cache_addr_reg <= {cur_index, beat_reg};
                    if (mem_req_reg && mem_ack) begin
                        mem_req_reg <= 1'b0;
                        cache_we_n_reg <= 1'b0;
                        cpu_ready_reg <= later_mode_reg || beat_reg == addr_reg[3:2];
                        beat_reg <= beat_reg + 2'h1;
                        if (beat_reg == `LAST_BEAT) begin
                            tag_we_n_reg <= 1'b0;
                            tag_wdata_reg <= cur_tag_full[8:0];
                            dmem_wr_reg <= 1'b1;
                            dmem_wdata_reg <= 1'b0;
                            state_reg <= `ST_DONE;
                        end
                    end
                end
                `ST_BYPASS: begin
                    mem_req_reg <= 1'b1;
                    mem_write_reg <= wr_reg;
                    mem_addr_reg <= addr_reg;
                    if (mem_req_reg && mem_ack) begin
                        mem_req_reg <= 1'b0;
                        cpu_ready_reg <= !master_reg;
                        if (wr_reg && master_reg && hit_reg) begin
                            cache_we_n_reg <= 1'b0;
                            snoop_n_reg <= 1'b0;
                        end
                        state_reg <= `ST_DONE;
                    end
                end
                `ST_DONE: begin
                    cyc_done_reg <= 1'b1;
                    state_reg <= `ST_IDLE;
                end
                default: begin
                    state_reg <= `ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign cyc_done = cyc_done_reg;
    assign cpu_ready = cpu_ready_reg;
    assign tag_index = tag_index_reg;
    assign tag_wdata = tag_wdata_reg;
    assign tag_we_n = tag_we_n_reg;
    assign cache_addr = cache_addr_reg;
    assign cache_oe_n = cache_oe_n_reg;
    assign cache_we_n = cache_we_n_reg;
    assign cache_interleave = later_mode_reg && !cache_size_sel[0];
    assign cache_bank_sel = (later_mode_reg && !cache_size_sel[0]) ?
        (phase_reg ^ cache_addr_reg[0]) : cache_addr_reg[0];
    assign mem_req = mem_req_reg;
    assign mem_write = mem_write_reg;
    assign mem_addr = mem_addr_reg;
    assign snoop_invalidate_strobe_n = snoop_n_reg;
    assign later_mode = later_mode_reg;
    assign ready_idle = (state_reg == `ST_IDLE);
    assign last_hit = hit_reg;

endmodule // writeback_cache_tag_control

`default_nettype wire

// ==== verif/cache_tag_monitor.sv ====
// cache_tag_monitor.sv: port assertions for the tag controller
// assumes a bind onto writeback_cache_tag_control, one clock
`timescale 1ns/1ns
`default_nettype none
module cache_tag_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // cycle
    input wire logic cyc_req,
    input wire logic cyc_write,
    input wire logic cyc_master,
    input wire logic cyc_done,
    input wire logic cpu_ready,
    input wire logic ready_idle,
    // srams, dram, mode
    input wire logic tag_we_n,
    input wire logic cache_we_n,
    input wire logic snoop_invalidate_strobe_n,
    input wire logic mem_req,
    input wire logic mem_ack,
    input wire logic mem_write,
    input wire logic [31:2] mem_addr,
    input wire logic later_mode,
    input wire logic cache_interleave,
    input wire logic [1:0] cache_size_sel
);
    // ------
    // cycle tracking
    // ------
    logic busy_reg, master_reg, write_reg;
    logic [1:0] age_reg;
    wire take = ready_idle && cyc_req;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_reg <= 1'b0;
            master_reg <= 1'b0;
            write_reg <= 1'b0;
            age_reg <= 2'h0;
        end else begin
            if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
            if (take) begin
                busy_reg <= 1'b1;
                master_reg <= cyc_master;
                write_reg <= cyc_write;
            end else if (cyc_done) busy_reg <= 1'b0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_TAG_PULSE: assert property (!tag_we_n |=> tag_we_n)
        else $error("tag we long");
    AST_CACHE_WE_PULSE: assert property (!cache_we_n |=> cache_we_n)
        else $error("cache we long");
    AST_NO_READY_MASTER: assert property (busy_reg && master_reg |-> !cpu_ready)
        else $error("ready in master cycle");
    AST_SNOOP_MASTER: assert property (!snoop_invalidate_strobe_n |-> master_reg && write_reg)
        else $error("stray snoop");
    AST_MEM_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("mem req dropped");
    AST_MODE_STABLE: assert property (age_reg == 2'h3 |-> $stable(later_mode))
        else $error("mode changed");
    AST_READY_IN_CYCLE: assert property (cpu_ready |-> busy_reg)
        else $error("stray ready");
    AST_DONE_BOUNDED: assert property (take |-> ##[2:400] cyc_done)
        else $error("cycle not done");
    AST_IDLE_AFTER_DONE: assert property (cyc_done |=> ready_idle)
        else $error("not idle");
    AST_INTERLEAVE: assert property (cache_interleave == (later_mode && !cache_size_sel[0]))
        else $error("interleave wrong");
    cover property (!snoop_invalidate_strobe_n);
    cover property (mem_req && mem_write && mem_ack && !write_reg);
    cover property (busy_reg && cpu_ready && !mem_req);
endmodule // cache_tag_monitor
`default_nettype wire

// ==== verif/cache_far_side_model.sv ====
// cache_far_side_model.sv: tag sram and dram answering with a delay
// assumes test indices below 16, same clock as the controller
`timescale 1ns/1ns
`default_nettype none
module cache_far_side_model (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // idle cycles before each ack
    input wire logic [1:0] ack_delay,
    // tag sram
    input wire logic [14:0] tag_index,
    input wire logic [8:0] tag_wdata,
    input wire logic tag_we_n,
    output logic [8:0] tag_rdata,
    // dram
    input wire logic mem_req,
    output logic mem_ack
);
    // ------
    // storage and answer
    // ------
    logic [8:0] tag_mem [0:15];
    logic [1:0] wait_reg;
    logic hold_reg;
    initial for (int i = 0; i < 16; i++) tag_mem[i] = 9'h1ff;
    assign tag_rdata = tag_mem[tag_index[3:0]];
    always @(posedge clk) if (!tag_we_n) tag_mem[tag_index[3:0]] <= tag_wdata;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_ack <= 1'b0;
            wait_reg <= 2'h0;
            hold_reg <= 1'b0;
        end else begin
            mem_ack <= 1'b0;
            hold_reg <= mem_ack;
            if (mem_req && !mem_ack && !hold_reg) begin
                if (wait_reg == ack_delay) begin
                    mem_ack <= 1'b1;
                    wait_reg <= 2'h0;
                end else wait_reg <= wait_reg + 2'h1;
            end
        end
    end
endmodule // cache_far_side_model
`default_nettype wire

// ==== verif/writeback_cache_tag_control_bench.sv ====
// writeback_cache_tag_control_bench.sv: cycle tests of the tag controller
// assumes 64k cache, CLEAR_ENTRIES 16, far side model on tag sram and dram
`timescale 1ns/1ns
`default_nettype none
module writeback_cache_tag_control_bench;
    // ------
    // stimulus and counts
    // ------
    logic clk = 0, rstn = 0, dclk = 0, strap = 0, wr_wait = 0, shadow = 0;
    logic req = 0, wr = 0, mst = 0;
    logic [1:0] size = 2'h0, burst = 2'h0, delay = 2'h0;
    logic [2:0] nc_en = 3'h0;
    logic [15:0] nc_base = 16'h0006;
    logic [31:2] addr = 30'h0, wb_addr;
    logic [8:0] tw_val;
    wire logic done, rdy, idle, hit, mreq, mwr, mack, tweb, cweb, snp_n, later, ilv;
    wire logic [8:0] trd, twd;
    wire logic [14:0] tidx;
    wire logic [31:2] maddr;
    int num_errors = 0, comparisons = 0, cyc = 0, t_take, t_r1, t_r2, t_done;
    int cnt [6];
    initial forever #25 clk = ~clk;
    initial forever begin
        #12 dclk = ~dclk;
        #13 dclk = ~dclk;
    end
    writeback_cache_tag_control #(.CLEAR_ENTRIES(16)) u_dut (.clk(clk), .rstn(rstn),
        .double_rate_clock(dclk), .cpu_type_strap(strap), .cache_size_sel(size),
        .burst_sel(burst), .write_hit_wait(wr_wait), .shadow_uncached(shadow),
        .uncached_enable(nc_en), .uncached_window_zero(nc_base),
        .uncached_window_one(nc_base), .uncached_window_two(nc_base),
        .uncached_size(6'h00), .cyc_req(req), .cyc_write(wr), .cyc_master(mst),
        .cyc_addr(addr), .cyc_done(done), .cpu_ready(rdy), .tag_index(tidx),
        .tag_rdata(trd), .tag_wdata(twd), .tag_we_n(tweb), .cache_addr(),
        .cache_oe_n(), .cache_we_n(cweb), .cache_interleave(ilv), .cache_bank_sel(),
        .mem_req(mreq), .mem_write(mwr), .mem_addr(maddr), .mem_ack(mack),
        .snoop_invalidate_strobe_n(snp_n), .later_mode(later), .ready_idle(idle),
        .last_hit(hit));
    cache_far_side_model u_far (.clk(clk), .rstn(rstn), .ack_delay(delay),
        .tag_index(tidx), .tag_wdata(twd), .tag_we_n(tweb), .tag_rdata(trd),
        .mem_req(mreq), .mem_ack(mack));
    always @(posedge clk) begin
        cyc++;
        if (idle === 1'b1 && req === 1'b1) t_take = cyc;
        if (rdy === 1'b1) begin
            cnt[2]++;
            if (cnt[2] == 1) t_r1 = cyc;
            if (cnt[2] == 2) t_r2 = cyc;
        end
        if (mreq === 1'b1 && mack === 1'b1 && mwr === 1'b1) begin
            if (cnt[0] == 0) wb_addr = maddr;
            cnt[0]++;
        end
        if (mreq === 1'b1 && mack === 1'b1 && mwr === 1'b0) cnt[1]++;
        if (cweb === 1'b0) cnt[3]++;
        if (tweb === 1'b0) begin
            cnt[4]++;
            tw_val = twd;
        end
        if (snp_n === 1'b0) cnt[5]++;
        if (done === 1'b1) t_done = cyc;
        if (cyc == 6000) begin
            num_errors++;
            give_verdict();
        end
    end
    function automatic logic [31:0] ad(input logic [8:0] tag, input logic [3:0] idx);
        return {7'h0, tag, 8'h0, idx, 4'h0};
    endfunction
    // packed counts: wb, fill, rdy, cwe, twe, snoop
    function automatic logic [23:0] pk();
        return {cnt[0][3:0], cnt[1][3:0], cnt[2][3:0], cnt[3][3:0], cnt[4][3:0], cnt[5][3:0]};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic w, input logic m, input logic [31:0] a);
        foreach (cnt[i]) cnt[i] = 0;
        t_done = 0;
        for (int k = 0; k < 100 && idle !== 1'b1; k++) #50;
        wr = w;
        mst = m;
        addr = a[31:2];
        req = 1'b1;
        #50 req = 1'b0;
        for (int k = 0; k < 400 && t_done == 0; k++) #50;
        if (t_done == 0) num_errors++;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        int lead0, d0;
        #630 rstn = 1'b1;
        #100 check(later, 1'b1);
        run(0, 0, ad(9'h005, 4'h1));
        check(pk(), 24'h044410);
        check(tw_val, 9'h005);
        run(0, 0, ad(9'h005, 4'h1));
        check({hit, pk()}, 25'h1004000);
        for (int i = 0; i < 2; i++) begin
            wr_wait = i[0];
            run(1, 0, ad(9'h005, 4'h1));
            if (i == 0) d0 = t_done - t_take;
            check(pk(), 24'h001100);
            check(t_done - t_take, d0 + i);
        end
        $display("test hits done");
        delay = 2'h3;
        run(0, 0, ad(9'h006, 4'h1));
        delay = 2'h0;
        check(pk(), 24'h444410);
        check({wb_addr, 2'h0}, ad(9'h005, 4'h1));
        run(0, 0, ad(9'h005, 4'h1));
        check(pk(), 24'h044410);
        run(1, 1, ad(9'h005, 4'h1));
        check(pk(), 24'h100101);
        run(0, 0, ad(9'h006, 4'h1));
        check(pk(), 24'h044410);
        run(1, 0, ad(9'h009, 4'h1));
        check(pk(), 24'h101000);
        run(0, 0, ad(9'h006, 4'h1));
        check({hit, pk()}, 25'h1004000);
        $display("test replacement done");
        for (int i = 0; i < 4; i++) begin
            nc_en = (i < 3) ? 3'h1 << i : 3'h0;
            shadow = (i == 3);
            run(0, 0, ad(9'h006, 4'h1));
            check({hit, cnt[3][3:0], cnt[4][3:0]}, 32'h0);
        end
        nc_en = 3'h0;
        shadow = 1'b0;
        $display("test uncached done");
        for (int b = 0; b < 4; b++) begin
            burst = b[1:0];
            run(0, 0, ad(9'h006, 4'h1));
            if (b == 0) lead0 = t_r1 - t_take;
            check(t_r1 - t_take, lead0 + b[0]);
            check(t_r2 - t_r1, 1 + b[1]);
        end
        for (int s = 0; s < 4; s++) begin
            size = s[1:0];
            #50 check(ilv, !s[0]);
        end
        size = 2'h0;
        $display("test timing done");
        strap = 1'b1;
        #200 check(later, 1'b1);
        rstn = 1'b0;
        #100 rstn = 1'b1;
        run(0, 0, ad(9'h006, 4'h1));
        check({later, pk()}, 25'h0001000);
        $display("test earlier mode done");
        give_verdict();
    end
endmodule // writeback_cache_tag_control_bench
bind writeback_cache_tag_control cache_tag_monitor u_mon (.*);
`default_nettype wire
